// ### hdl/acpc_clk_div.v
// ratio divider for the converter clock: divides an enable stream by 1/2/4/8
// assumes src_tick is a one-cycle enable on ref_clk
`timescale 1ns/1ns
`default_nettype none
module acpc_clk_div (
	input  wire       ref_clk,
	input  wire       rst_n,
	input  wire       src_tick,
	input  wire [1:0] ratio,
	output reg        out_tick
);
	reg  [2:0] count;
	reg  [2:0] limit;

	always @* begin
		case (ratio)
			2'h0:    limit = 3'h0;
			2'h1:    limit = 3'h1;
			2'h2:    limit = 3'h3;
			default: limit = 3'h7;
		endcase
	end

	// ratio changes apply to the count in progress, a short glitch at worst
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count    <= 3'h0;
			out_tick <= 1'b0;
		end else begin
			out_tick <= 1'b0;
			if (src_tick) begin
				if (count >= limit) begin
					count    <= 3'h0;
					out_tick <= 1'b1;
				end else begin
					count <= count + 3'h1;
				end
			end
		end
	end
endmodule // acpc_clk_div
`default_nettype wire

// ### hdl/acpc_defines.vh
// constants for the converter configuration and analog pin control block
// assumes an apb master with 32-bit data and one clock domain
`ifndef ACPC_DEFINES_VH
`define ACPC_DEFINES_VH

// ********************************************
// register map (byte addresses)
// ********************************************
`define ACPC_ADDR_CFG       12'h000
`define ACPC_ADDR_PIN_LOW   12'h004
`define ACPC_ADDR_PIN_MID   12'h008
`define ACPC_RESET_VALUE    8'h00

// ********************************************
// configuration fields
// ********************************************
`define ACPC_LOW_POWER_BIT  7
`define ACPC_DIV_HI         6
`define ACPC_DIV_LO         5
`define ACPC_LONG_SMP_BIT   4
`define ACPC_MODE_HI        3
`define ACPC_MODE_LO        2
`define ACPC_SRC_HI         1
`define ACPC_SRC_LO         0

`define ACPC_MODE_8BIT      2'h0
`define ACPC_MODE_12BIT     2'h1
`define ACPC_MODE_10BIT     2'h2
`define ACPC_MODE_RSVD      2'h3

`define ACPC_SRC_BUS        2'h0
`define ACPC_SRC_BUS_HALF   2'h1
`define ACPC_SRC_ALT        2'h2
`define ACPC_SRC_ASYNC      2'h3

`define ACPC_CHANNELS       16

`endif

// ### hdl/acpc_top.v
// apb register block for converter configuration and analog pin control
// assumes apb master on ref_clk; alternate and internal clock ticks come
// from other domains as levels that rise once per source period
// apb data are 32 bits wide; each register sits in the low byte of a word
// pin-control outputs are active high: a set bit forces its pin
// every register resets to zero, so the bus clock is the source after reset
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "acpc_defines.vh"
module acpc_top (
	input  wire        ref_clk,
	input  wire        arst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        alternate_clock,
	input  wire        internal_async_clock,
	output reg         converter_clock,
	output reg         low_power_select,
	output reg         long_sample_select,
	output reg  [1:0]  conversion_mode,
	output reg         mode_reserved_error,
	output reg  [15:0] pin_release,
	output reg  [15:0] port_out_hiz,
	output reg  [15:0] port_in_disable,
	output reg  [15:0] pullup_disable
);
	// ********************************************
	// reset release
	// ********************************************
	reg        rst_meta;
	reg        rst_n;

	// reset asserts at once but releases on a clock edge, so no flop sees
	// its reset removed close to the sampling edge
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ********************************************
	// registers and apb slave
	// ********************************************
	reg  [7:0] converter_configuration;
	reg  [7:0] analog_pin_select_low;
	reg  [7:0] analog_pin_select_mid;
	wire       access;
	wire       hit_cfg;
	wire       hit_low;
	wire       hit_mid;
	wire       mapped;
	reg  [7:0] next_rdata;

	// access is high only in the first access cycle of a transfer
	assign access  = psel && penable && !pready;
	assign hit_cfg = (paddr == `ACPC_ADDR_CFG);
	assign hit_low = (paddr == `ACPC_ADDR_PIN_LOW);
	assign hit_mid = (paddr == `ACPC_ADDR_PIN_MID);
	assign mapped  = hit_cfg || hit_low || hit_mid;

	// only the low byte exists; upper read bits stay zero
	always @* begin
		next_rdata = 8'h00;
		if (hit_cfg)
			next_rdata = converter_configuration;
		else if (hit_low)
			next_rdata = analog_pin_select_low;
		else if (hit_mid)
			next_rdata = analog_pin_select_mid;
	end

	// one wait state: pready rises in the second access cycle
	// the transfer is taken in the first access cycle, while pready is low;
	// the register is written there and pready answers one edge later
	// unmapped offsets answer with an error and drop the write
	// a write with byte lane 0 off is ignored without an error
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			converter_configuration <= `ACPC_RESET_VALUE;
			analog_pin_select_low   <= `ACPC_RESET_VALUE;
			analog_pin_select_mid   <= `ACPC_RESET_VALUE;
			prdata                  <= 32'h00000000;
			pready                  <= 1'b0;
			pslverr                 <= 1'b0;
		end else begin
			pready  <= access;
			pslverr <= access && !mapped;
			prdata  <= 32'h00000000;
			if (access && !pwrite)
				prdata <= {24'h000000, next_rdata};
			if (access && pwrite && pstrb[0]) begin
				if (hit_cfg)
					converter_configuration <= pwdata[7:0];
				if (hit_low)
					analog_pin_select_low <= pwdata[7:0];
				if (hit_mid)
					analog_pin_select_mid <= pwdata[7:0];
			end
		end
	end

	// ********************************************
	// configuration outputs
	// ********************************************
	wire [1:0]  src_sel;
	wire [1:0]  div_sel;
	wire [15:0] pins;

	assign src_sel = converter_configuration[`ACPC_SRC_HI:`ACPC_SRC_LO];
	assign div_sel = converter_configuration[`ACPC_DIV_HI:`ACPC_DIV_LO];
	// the mid register holds channels 8 to 15 in the upper half of pins
	assign pins    = {analog_pin_select_mid, analog_pin_select_low};

	// field outputs are registered copies one edge behind the register,
	// so a converter never sees a half-updated configuration word
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_power_select    <= 1'b0;
			long_sample_select  <= 1'b0;
			conversion_mode     <= `ACPC_MODE_8BIT;
			mode_reserved_error <= 1'b0;
		end else begin
			// clear is high speed, set is low power
			low_power_select <= converter_configuration[`ACPC_LOW_POWER_BIT];
			long_sample_select <= converter_configuration[`ACPC_LONG_SMP_BIT];
			conversion_mode <=
				converter_configuration[`ACPC_MODE_HI:`ACPC_MODE_LO];
			// software must not program the reserved mode; flag it if it does
			mode_reserved_error <= (converter_configuration[
				`ACPC_MODE_HI:`ACPC_MODE_LO] == `ACPC_MODE_RSVD);
		end
	end

	// ********************************************
	// pin control, one slice per channel
	// ********************************************
	// all four controls of a pin follow one bit on the same edge, so a pin
	// is never left driven while its input buffer is already off
	genvar ch;
	generate
		for (ch = 0; ch < `ACPC_CHANNELS; ch = ch + 1) begin : g_pin
			always @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					pin_release[ch]     <= 1'b0;
					port_out_hiz[ch]    <= 1'b0;
					port_in_disable[ch] <= 1'b0;
					pullup_disable[ch]  <= 1'b0;
				end else begin
					pin_release[ch]     <= pins[ch];
					port_out_hiz[ch]    <= pins[ch];
					port_in_disable[ch] <= pins[ch];
					pullup_disable[ch]  <= pins[ch];
				end
			end
		end
	endgenerate

	// ********************************************
	// converter clock source and divide
	// ********************************************
	// the alternate and internal clocks are sampled, never used as clocks:
	// each passes two flops and only its rising edge makes a tick, so they
	// must run below half of ref_clk to be seen
	// bus_half marks every other cycle for the halved bus clock source
	reg  [1:0] alt_sync;
	reg  [1:0] int_sync;
	reg        alt_last;
	reg        int_last;
	reg        bus_half;
	reg        src_tick;
	wire       div_tick;

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alt_sync <= 2'h0;
			int_sync <= 2'h0;
			alt_last <= 1'b0;
			int_last <= 1'b0;
			bus_half <= 1'b0;
			src_tick <= 1'b0;
		end else begin
			alt_sync <= {alt_sync[0], alternate_clock};
			int_sync <= {int_sync[0], internal_async_clock};
			alt_last <= alt_sync[1];
			int_last <= int_sync[1];
			bus_half <= ~bus_half;
			case (src_sel)
				`ACPC_SRC_BUS:      src_tick <= 1'b1;
				`ACPC_SRC_BUS_HALF: src_tick <= bus_half;
				`ACPC_SRC_ALT:      src_tick <= alt_sync[1] & ~alt_last;
				default:            src_tick <= int_sync[1] & ~int_last;
			endcase
		end
	end

	// the divider counts ticks, not edges, so every source divides alike
	acpc_clk_div u_div (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.src_tick (src_tick),
		.ratio    (div_sel),
		.out_tick (div_tick)
	);

	// converter clock toggles on every divided tick, so it runs at half rate
	// and its period is twice the divided tick period
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			converter_clock <= 1'b0;
		else if (div_tick)
			converter_clock <= ~converter_clock;
	end
endmodule // acpc_top
`default_nettype wire

// ### verif/acpc_top_asserts.sv
// checker for acpc_top: register writes reach the outputs, apb timing
// assumes it is bound to acpc_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module acpc_chk (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic        low_power_select,
	input wire logic        long_sample_select,
	input wire logic [1:0]  conversion_mode,
	input wire logic        mode_reserved_error,
	input wire logic [15:0] pin_release,
	input wire logic [15:0] port_out_hiz
);
	// outputs are registered copies, so they trail the write by one edge
	wire wr = psel && penable && pready && pwrite && pstrb[0];
	wire cfg = wr && paddr == 12'h000;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	a_low_power: assert property (cfg |=>
		low_power_select == $past(pwdata[7])) else $error("lp");
	a_long_sample: assert property (cfg |=>
		long_sample_select == $past(pwdata[4])) else $error("ls");
	a_mode_field: assert property (cfg |=>
		conversion_mode == $past(pwdata[3:2])) else $error("mode");
	a_mode_flag: assert property (cfg |=>
		mode_reserved_error == ($past(pwdata[3:2]) == 2'h3))
		else $error("flag");
	a_pin_low: assert property (wr && paddr == 12'h004 |=>
		pin_release[7:0] == $past(pwdata[7:0])) else $error("low");
	a_pin_mid: assert property (wr && paddr == 12'h008 |=>
		pin_release[15:8] == $past(pwdata[7:0])) else $error("mid");
	a_pin_hiz: assert property (wr && paddr == 12'h008 |=>
		port_out_hiz[15:8] == $past(pwdata[7:0])) else $error("hiz");
	a_ready_wait: assert property (psel && penable && !pready |=>
		pready ##1 !pready) else $error("ready");
	c_cfg: cover property (cfg);
	c_flag: cover property (mode_reserved_error);
	c_hiz: cover property (port_out_hiz[15]);
endmodule // acpc_chk

bind acpc_top acpc_chk acpc_chk_i (.ref_clk, .arst_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .pready, .low_power_select,
	.long_sample_select, .conversion_mode, .mode_reserved_error,
	.pin_release, .port_out_hiz);
`default_nettype wire

// ### verif/acpc_top_bench.sv
// bench for acpc_top: apb access, config and pin outputs, clock divide
// assumes the design files and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module acpc_top_bench;
	logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic        alternate_clock, internal_async_clock, converter_clock;
	logic        low_power_select, long_sample_select, mode_reserved_error;
	logic [1:0]  conversion_mode;
	logic [3:0]  pstrb;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] pin_release, port_out_hiz, port_in_disable, pullup_disable;
	int          bad_count, checked, cyc, i, n;
	acpc_top acpc_top_i (.ref_clk, .arst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.alternate_clock, .internal_async_clock, .converter_clock,
		.low_power_select, .long_sample_select, .conversion_mode,
		.mode_reserved_error, .pin_release, .port_out_hiz,
		.port_in_disable, .pullup_disable);
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task complete_run;
		if (bad_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// the error flag is folded into bit 31, which mapped reads keep at 0
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk);
		penable <= 1'h1;
		// answer is taken at the very edge that samples pready high
		do @(posedge ref_clk); while (pready !== 1'h1);
		rd = prdata | {pslverr, 31'h0};
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task t_reset;
		apb(0, 12'h000, 0, 4'hf);
		chk(rd, 0);
		apb(0, 12'h008, 0, 4'hf);
		chk(rd, 0);
	endtask
	task t_cfg;
		logic [7:0] v;
		for (i = 0; i < 4; i++) begin
			v = {i[0], i[1:0], i[1], i[1:0], i[1:0]};
			apb(1, 12'h000, {24'h0, v}, 4'h1);
			apb(0, 12'h000, 0, 4'hf);
			chk(rd, {24'h0, v});
			chk({low_power_select, long_sample_select, conversion_mode,
				mode_reserved_error}, {v[7], v[4], v[3:2], v[3:2] == 2'h3});
		end
	endtask
	task t_pin;
		logic [15:0] p;
		for (i = 0; i < 17; i++) begin
			p = 16'h1 << i;
			apb(1, 12'h004, {24'h0, p[7:0]}, 4'h1);
			apb(1, 12'h008, {24'h0, p[15:8]}, 4'h1);
			@(negedge ref_clk);
			chk({pin_release, pullup_disable}, {p, p});
			chk({port_out_hiz, port_in_disable}, {p, p});
		end
	endtask
	task clk_case(input logic [1:0] s, input logic [1:0] d, input int e);
		apb(1, 12'h000, {25'h0, d, 3'h0, s}, 4'h1);
		repeat (40) @(negedge ref_clk);
		n = 0;
		while (converter_clock !== 1'h0) @(negedge ref_clk);
		while (converter_clock !== 1'h1) @(negedge ref_clk);
		do begin @(negedge ref_clk); n++; end while (converter_clock === 1'h1);
		do begin @(negedge ref_clk); n++; end while (converter_clock === 1'h0);
		chk(n, e);
	endtask
	task t_clk;
		for (i = 0; i < 8; i++)
			clk_case({1'b0, i[2]}, i[1:0], 2 << (i % 4 + i / 4));
		// alternate rises every 16 cycles, internal every 32
		clk_case(2'h2, 2'h0, 32);
		clk_case(2'h3, 2'h1, 128);
	endtask
	task t_bad;
		apb(0, 12'h00c, 0, 4'hf);
		chk(rd, 32'h80000000);
		apb(1, 12'h00c, 32'h000000ff, 4'h1);
		chk(rd, 32'h80000000);
	endtask
	task t_rerun;
		apb(1, 12'h000, 32'h00000041, 4'h1);
		apb(1, 12'h000, 32'h00000090, 4'h2);
		apb(0, 12'h000, 0, 4'hf);
		chk(rd, 32'h00000041);
		apb(1, 12'h004, 32'h000000a5, 4'h1);
		@(posedge ref_clk);
		arst_n <= 1'h0;
		@(negedge ref_clk);
		chk({converter_clock, low_power_select, pin_release}, 0);
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'h1;
		repeat (3) @(posedge ref_clk);
		apb(0, 12'h000, 0, 4'hf);
		chk(rd, 0);
		apb(0, 12'h004, 0, 4'hf);
		chk(rd, 0);
	endtask
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc[2:0] == 0) alternate_clock <= ~alternate_clock;
		if (cyc[3:0] == 5) internal_async_clock <= ~internal_async_clock;
		if (cyc == 8000) begin
			bad_count++;
			complete_run;
		end
	end
	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{alternate_clock, internal_async_clock} = '0;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'h1;
		repeat (3) @(posedge ref_clk);
		t_reset;
		t_cfg;
		t_pin;
		t_clk;
		t_bad;
		t_rerun;
		complete_run;
	end
endmodule // acpc_top_bench
`default_nettype wire
